// ===== logic/ldu_params.svh
// constants for the zero-extending load unit
`ifndef LDU_PARAMS_SVH
`define LDU_PARAMS_SVH

`define LDU_XLEN 32
`define LDU_IMM_W 16
`define LDU_REG_IDX_W 5
`define LDU_CAUSE_W 5
`define LDU_CAUSE_NONE 5'h00
`define LDU_CAUSE_UNALIGNED 5'h01
`define LDU_CAUSE_STORAGE 5'h10
`define LDU_CAUSE_XLATE_MISS 5'h12
`define LDU_HALF_FLIP 32'h0000_0002
`define LDU_BYTE_W 8
`define LDU_HALF_W 16
`define LDU_AREA_DEFAULT 1'h0
`define LDU_REORDER_DEFAULT 1'h1

`endif

// ===== logic/ldu_pkg.sv
// types shared by the load unit and its bench
package ldu_pkg;
    typedef enum logic [1:0] {
        LDU_OP_BYTE_IMM,
        LDU_OP_HALF_REG,
        LDU_OP_HALF_IMM,
        LDU_OP_WORD_REG
    } ldu_op_t;

    typedef enum logic [1:0] {
        LDU_SZ_BYTE,
        LDU_SZ_HALF,
        LDU_SZ_WORD
    } ldu_size_t;
endpackage

// ===== logic/ldu_load_unit.sv
// execution unit for zero-extending loads with exception checks
`timescale 1ns/10ps
`include "ldu_params.svh"

// Functional notes
// - register forms: address is sum of both source registers
// - immediate forms: address is first source plus sign-extended 16-bit constant
// - byte load fills low byte, clears upper 24 bits
// - halfword load fills low halfword, clears upper 16 bits
// - word load faults unaligned unless low two address bits zero
// - halfword load faults when address bit zero set; bytes never checked
// - virtual mode and no translation gives cause 10010, store flag cleared
// - user and virtual mode with forbidden zone gives 10000, zone bit set
// - on miss or storage fault save mode flags then clear both
// - unaligned gives 00001, store clear, destination index, word-size bit
// - priority: translation miss, then zone protection, then alignment
// - any fault leaves destination unchanged, no writeback
// - reversed halfword uses flipped halfword location and swaps bytes
// - reversed word swaps all four bytes
// - reversed forms accepted only when reorder parameter is one
// - completion takes one cycle, or two when area-optimised
// - immediate sign extension replaced when prefix directly precedes
// - prefix supplies upper 16 bits; interrupts held off until next instruction
module ldu_load_unit #(
    parameter logic area_optimised_param = `LDU_AREA_DEFAULT,
    parameter logic reorder_enable_param = `LDU_REORDER_DEFAULT
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    // pipeline issue side
    input wire logic issue_valid_i,
    input wire ldu_pkg::ldu_op_t issue_op_i,
    input wire logic issue_reversed_i,
    input wire logic [`LDU_XLEN-1:0] first_src_gpr_i,
    input wire logic [`LDU_XLEN-1:0] second_src_gpr_i,
    input wire logic [`LDU_IMM_W-1:0] imm_field_i,
    input wire logic [`LDU_REG_IDX_W-1:0] dest_idx_i,
    input wire logic prefix_valid_i,
    input wire logic [`LDU_IMM_W-1:0] prefix_value_i,
    input wire logic other_issue_i,
    output logic issue_ready_o,
    output logic illegal_o,
    output logic irq_hold_o,
    // machine state flags written by the pipeline
    input wire logic msr_write_i,
    input wire logic msr_user_i,
    input wire logic msr_virtual_i,
    output logic user_mode_flag_o,
    output logic virtual_mode_flag_o,
    output logic saved_user_flag_o,
    output logic saved_virtual_flag_o,
    // translation unit
    output logic xlate_req_o,
    output logic [`LDU_XLEN-1:0] xlate_addr_o,
    input wire logic xlate_valid_i,
    input wire logic xlate_miss_i,
    input wire logic zone_forbid_i,
    // data memory bus
    output logic mem_req_o,
    output logic [`LDU_XLEN-1:0] mem_addr_o,
    output ldu_pkg::ldu_size_t mem_size_o,
    input wire logic mem_ack_i,
    input wire logic [`LDU_XLEN-1:0] mem_rdata_i,
    // writeback
    output logic wb_valid_o,
    output logic [`LDU_REG_IDX_W-1:0] wb_idx_o,
    output logic [`LDU_XLEN-1:0] wb_data_o,
    // exception status
    output logic exc_valid_o,
    output logic [`LDU_CAUSE_W-1:0] exception_cause_code_o,
    output logic exc_store_o,
    output logic zone_protect_cause_o,
    output logic exc_word_o,
    output logic [`LDU_REG_IDX_W-1:0] exc_reg_idx_o
);

    typedef enum logic [1:0] {
        LDU_ST_IDLE,
        LDU_ST_CHECK,
        LDU_ST_MEM,
        LDU_ST_LATENCY
    } ldu_state_t;

    // operand size of an opcode, used by both the check and placement paths
    function automatic ldu_pkg::ldu_size_t op_size(input ldu_pkg::ldu_op_t op);
        case (op)
            ldu_pkg::LDU_OP_BYTE_IMM: op_size = ldu_pkg::LDU_SZ_BYTE;
            ldu_pkg::LDU_OP_WORD_REG: op_size = ldu_pkg::LDU_SZ_WORD;
            default: op_size = ldu_pkg::LDU_SZ_HALF;
        endcase
    endfunction

    ldu_state_t state_reg;
    ldu_pkg::ldu_op_t op_reg;
    logic reversed_reg;
    logic [`LDU_REG_IDX_W-1:0] dest_reg;
    logic prefix_lock_reg;
    logic [`LDU_IMM_W-1:0] prefix_val_reg;
    logic user_reg;
    logic virt_reg;
    logic [`LDU_XLEN-1:0] rdata_reg;

    logic is_imm;
    logic rev_illegal;
    logic [`LDU_XLEN-1:0] imm_ext;
    logic [`LDU_XLEN-1:0] eff_addr;
    logic [`LDU_XLEN-1:0] addr_next;
    logic take;
    logic fault_miss;
    logic fault_zone;
    logic fault_align;
    logic [`LDU_XLEN-1:0] load_data;
    logic [`LDU_XLEN-1:0] raw_data;
    logic finish;

    // operand formation; the prefix replaces sign extension
    always_comb begin
        is_imm = (issue_op_i == ldu_pkg::LDU_OP_BYTE_IMM) ||
                 (issue_op_i == ldu_pkg::LDU_OP_HALF_IMM);
        rev_illegal = issue_reversed_i && !reorder_enable_param;
        if (prefix_lock_reg) begin
            imm_ext = {prefix_val_reg, imm_field_i};
        end else begin
            imm_ext = {{(`LDU_XLEN-`LDU_IMM_W){imm_field_i[`LDU_IMM_W-1]}}, imm_field_i};
        end
        if (is_imm) begin
            eff_addr = first_src_gpr_i + imm_ext;
        end else begin
            eff_addr = first_src_gpr_i + second_src_gpr_i;
        end
        // reversed halfword reads the other halfword of the word
        if (issue_reversed_i && op_size(issue_op_i) == ldu_pkg::LDU_SZ_HALF) begin
            addr_next = eff_addr ^ `LDU_HALF_FLIP;
        end else begin
            addr_next = eff_addr;
        end
        take = issue_valid_i && issue_ready_o && !rev_illegal;
    end

    // check results, evaluated in fixed priority
    always_comb begin
        fault_miss = virt_reg && xlate_miss_i;
        fault_zone = !fault_miss && user_reg && virt_reg && zone_forbid_i;
        fault_align = 1'b0;
        if (op_size(op_reg) == ldu_pkg::LDU_SZ_WORD) begin
            fault_align = (mem_addr_o[1:0] != 2'h0);
        end else if (op_size(op_reg) == ldu_pkg::LDU_SZ_HALF) begin
            fault_align = mem_addr_o[0];
        end
        fault_align = fault_align && !fault_miss && !fault_zone;
    end

    // data placement with zero extension and optional byte swap
    always_comb begin
        raw_data = mem_rdata_i;
        case (op_size(op_reg))
            ldu_pkg::LDU_SZ_BYTE: begin
                load_data = {{(`LDU_XLEN-`LDU_BYTE_W){1'b0}}, raw_data[`LDU_BYTE_W-1:0]};
            end
            ldu_pkg::LDU_SZ_HALF: begin
                if (reversed_reg) begin
                    load_data = {{(`LDU_XLEN-`LDU_HALF_W){1'b0}},
                                 raw_data[7:0], raw_data[15:8]};
                end else begin
                    load_data = {{(`LDU_XLEN-`LDU_HALF_W){1'b0}}, raw_data[`LDU_HALF_W-1:0]};
                end
            end
            default: begin
                if (reversed_reg) begin
                    load_data = {raw_data[7:0], raw_data[15:8],
                                 raw_data[23:16], raw_data[31:24]};
                end else begin
                    load_data = raw_data;
                end
            end
        endcase
        finish = (state_reg == LDU_ST_MEM && mem_ack_i && !area_optimised_param) ||
                 (state_reg == LDU_ST_LATENCY);
    end

    // sequencing: check, then read, then optional extra stage
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= LDU_ST_IDLE;
            issue_ready_o <= 1'b1;
            xlate_req_o <= 1'b0;
            mem_req_o <= 1'b0;
        end else begin
            case (state_reg)
                LDU_ST_IDLE: begin
                    if (take) begin
                        state_reg <= LDU_ST_CHECK;
                        issue_ready_o <= 1'b0;
                        xlate_req_o <= 1'b1;
                    end
                end
                LDU_ST_CHECK: begin
                    if (xlate_valid_i) begin
                        xlate_req_o <= 1'b0;
                        if (fault_miss || fault_zone || fault_align) begin
                            state_reg <= LDU_ST_IDLE;
                            issue_ready_o <= 1'b1;
                        end else begin
                            state_reg <= LDU_ST_MEM;
                            mem_req_o <= 1'b1;
                        end
                    end
                end
                LDU_ST_MEM: begin
                    if (mem_ack_i) begin
                        mem_req_o <= 1'b0;
                        if (area_optimised_param) begin
                            state_reg <= LDU_ST_LATENCY;
                        end else begin
                            state_reg <= LDU_ST_IDLE;
                            issue_ready_o <= 1'b1;
                        end
                    end
                end
                LDU_ST_LATENCY: begin
                    state_reg <= LDU_ST_IDLE;
                    issue_ready_o <= 1'b1;
                end
                default: begin
                    state_reg <= LDU_ST_IDLE;
                    issue_ready_o <= 1'b1;
                    xlate_req_o <= 1'b0;
                    mem_req_o <= 1'b0;
                end
            endcase
        end
    end

    // request capture; address is held steady for both translation and bus
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            op_reg <= ldu_pkg::LDU_OP_BYTE_IMM;
            reversed_reg <= 1'b0;
            dest_reg <= '0;
            xlate_addr_o <= '0;
            mem_addr_o <= '0;
            mem_size_o <= ldu_pkg::LDU_SZ_BYTE;
        end else if (take) begin
            op_reg <= issue_op_i;
            reversed_reg <= issue_reversed_i;
            dest_reg <= dest_idx_i;
            xlate_addr_o <= addr_next;
            mem_addr_o <= addr_next;
            mem_size_o <= op_size(issue_op_i);
        end
    end

    // rejected reversed forms are flagged for one cycle and not executed
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            illegal_o <= 1'b0;
        end else begin
            illegal_o <= issue_valid_i && issue_ready_o && rev_illegal;
        end
    end

    // prefix lock: lives until the very next instruction of any kind
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prefix_lock_reg <= 1'b0;
            prefix_val_reg <= '0;
            irq_hold_o <= 1'b0;
        end else if (prefix_valid_i) begin
            prefix_lock_reg <= 1'b1;
            prefix_val_reg <= prefix_value_i;
            irq_hold_o <= 1'b1;
        end else if ((issue_valid_i && issue_ready_o) || other_issue_i) begin
            prefix_lock_reg <= 1'b0;
            irq_hold_o <= 1'b0;
        end
    end

    // mode flags; a fault in the same cycle wins over a pipeline write
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            user_reg <= 1'b0;
            virt_reg <= 1'b0;
            saved_user_flag_o <= 1'b0;
            saved_virtual_flag_o <= 1'b0;
        end else if (state_reg == LDU_ST_CHECK && xlate_valid_i && (fault_miss || fault_zone)) begin
            saved_user_flag_o <= user_reg;
            saved_virtual_flag_o <= virt_reg;
            user_reg <= 1'b0;
            virt_reg <= 1'b0;
        end else if (msr_write_i) begin
            user_reg <= msr_user_i;
            virt_reg <= msr_virtual_i;
        end
    end

    // live flags are exported from their own copies so outputs stay registered
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            user_mode_flag_o <= 1'b0;
            virtual_mode_flag_o <= 1'b0;
        end else begin
            user_mode_flag_o <= user_reg;
            virtual_mode_flag_o <= virt_reg;
        end
    end

    // exception status; fields not named by a fault keep their old value
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            exc_valid_o <= 1'b0;
            exception_cause_code_o <= `LDU_CAUSE_NONE;
            exc_store_o <= 1'b0;
            zone_protect_cause_o <= 1'b0;
            exc_word_o <= 1'b0;
            exc_reg_idx_o <= '0;
        end else begin
            exc_valid_o <= 1'b0;
            if (state_reg == LDU_ST_CHECK && xlate_valid_i) begin
                if (fault_miss) begin
                    exc_valid_o <= 1'b1;
                    exception_cause_code_o <= `LDU_CAUSE_XLATE_MISS;
                    exc_store_o <= 1'b0;
                end else if (fault_zone) begin
                    exc_valid_o <= 1'b1;
                    exception_cause_code_o <= `LDU_CAUSE_STORAGE;
                    exc_store_o <= 1'b0;
                    zone_protect_cause_o <= 1'b1;
                end else if (fault_align) begin
                    exc_valid_o <= 1'b1;
                    exception_cause_code_o <= `LDU_CAUSE_UNALIGNED;
                    exc_store_o <= 1'b0;
                    exc_word_o <= (op_size(op_reg) == ldu_pkg::LDU_SZ_WORD);
                    exc_reg_idx_o <= dest_reg;
                end
            end
        end
    end

    // area build holds read data one extra cycle before writeback
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_reg <= '0;
        end else if (state_reg == LDU_ST_MEM && mem_ack_i) begin
            rdata_reg <= load_data;
        end
    end

    // writeback only on a clean completion
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wb_valid_o <= 1'b0;
            wb_idx_o <= '0;
            wb_data_o <= '0;
        end else begin
            wb_valid_o <= finish;
            if (finish) begin
                wb_idx_o <= dest_reg;
                wb_data_o <= (state_reg == LDU_ST_LATENCY) ? rdata_reg : load_data;
            end
        end
    end

endmodule

// ===== tb/ldu_load_unit_asserts.sv
// port-level assertions for the load unit
`timescale 1ns/10ps
module ldu_load_unit_asserts #(
    parameter logic area_optimised_param = 1'h0,
    parameter logic reorder_enable_param = 1'h1
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic issue_valid_i,
    input wire logic issue_reversed_i,
    input wire logic issue_ready_o,
    input wire logic user_mode_flag_o,
    input wire logic virtual_mode_flag_o,
    input wire logic saved_user_flag_o,
    input wire logic saved_virtual_flag_o,
    input wire logic xlate_req_o,
    input wire logic xlate_valid_i,
    input wire logic xlate_miss_i,
    input wire logic zone_forbid_i,
    input wire logic mem_req_o,
    input wire logic [31:0] mem_addr_o,
    input wire ldu_pkg::ldu_size_t mem_size_o,
    input wire logic mem_ack_i,
    input wire logic wb_valid_o,
    input wire logic [31:0] wb_data_o,
    input wire logic exc_valid_o,
    input wire logic [4:0] exception_cause_code_o,
    input wire logic exc_store_o,
    input wire logic zone_protect_cause_o
);
    localparam int WB_LAT = area_optimised_param ? 2 : 1;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // translation answers that must end in a fault, and a finished memory read
    sequence xl_miss;
        xlate_req_o && xlate_valid_i && virtual_mode_flag_o && xlate_miss_i;
    endsequence
    sequence xl_zone;
        xlate_req_o && xlate_valid_i && !xlate_miss_i && zone_forbid_i
            && user_mode_flag_o && virtual_mode_flag_o;
    endsequence
    sequence mem_done;
        mem_req_o && mem_ack_i;
    endsequence
    // a refused reversed load must not reach translation, so it is excluded here
    issue_xlate_a: assert property (issue_valid_i && issue_ready_o
        && !(issue_reversed_i && !reorder_enable_param) |=> xlate_req_o && !issue_ready_o)
        else $error("accepted load did not start translation");
    miss_cause_a: assert property (xl_miss |=> exc_valid_o && !exc_store_o
        && exception_cause_code_o == 5'h12 && !mem_req_o)
        else $error("translation miss not reported");
    zone_cause_a: assert property (xl_zone |=> exc_valid_o && !exc_store_o
        && exception_cause_code_o == 5'h10 && zone_protect_cause_o && !mem_req_o)
        else $error("zone fault not reported");
    mode_save_a: assert property (xl_miss or xl_zone |=>
        saved_user_flag_o == $past(user_mode_flag_o) && saved_virtual_flag_o
        ##1 !user_mode_flag_o && !virtual_mode_flag_o)
        else $error("mode flags not saved and cleared");
    fault_quiet_a: assert property (exc_valid_o |-> !wb_valid_o && !mem_req_o)
        else $error("fault with writeback or memory read");
    align_req_a: assert property (mem_req_o |->
        !(mem_size_o == ldu_pkg::LDU_SZ_WORD && mem_addr_o[1:0] != 2'h0)
        && !(mem_size_o == ldu_pkg::LDU_SZ_HALF && mem_addr_o[0]))
        else $error("misaligned memory request");
    wb_latency_a: assert property (mem_done |-> ##WB_LAT wb_valid_o && issue_ready_o)
        else $error("writeback latency wrong");
    byte_zero_a: assert property (mem_done and mem_size_o == ldu_pkg::LDU_SZ_BYTE
        |-> ##WB_LAT wb_data_o[31:8] == 24'h0)
        else $error("byte load upper bits not cleared");
    half_zero_a: assert property (mem_done and mem_size_o == ldu_pkg::LDU_SZ_HALF
        |-> ##WB_LAT wb_data_o[31:16] == 16'h0)
        else $error("halfword load upper bits not cleared");
endmodule
bind ldu_load_unit ldu_load_unit_asserts #(.area_optimised_param(area_optimised_param),
    .reorder_enable_param(reorder_enable_param)) chk (.*);

// ===== tb/ldu_mem_model.sv
// far-side model: translation answers and a data memory
`timescale 1ns/10ps
module ldu_mem_model (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic xreq_i,
    input wire logic mreq_i,
    input wire logic [31:0] maddr_i,
    input wire logic miss_i,
    input wire logic zone_i,
    input wire logic [1:0] lag_i,
    output logic xvalid_o,
    output logic xmiss_o,
    output logic xzone_o,
    output logic ack_o,
    output logic [31:0] rdata_o
);
    logic [1:0] wait_reg;
    // bytes 0, 1 and 3 always differ and byte 2 follows address bits 15:8, so slices and swaps show in the result
    function automatic logic [31:0] mem_word(input logic [31:0] a);
        return {a[7:0] ^ 8'h3c, a[15:8], ~a[7:0], a[7:0] ^ 8'ha5};
    endfunction
    // answer after lag_i idle cycles; lines not answering toggle so no stale value passes
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wait_reg <= 2'h0;
            xvalid_o <= 1'h0;
            ack_o <= 1'h0;
            xmiss_o <= 1'h0;
            xzone_o <= 1'h0;
            rdata_o <= 32'h0;
        end else begin
            xvalid_o <= 1'h0;
            ack_o <= 1'h0;
            xmiss_o <= ~xmiss_o;
            xzone_o <= ~xzone_o;
            rdata_o <= ~rdata_o;
            if ((xreq_i && !xvalid_o) || (mreq_i && !ack_o)) begin
                wait_reg <= wait_reg + 2'h1;
                if (wait_reg == lag_i) begin
                    wait_reg <= 2'h0;
                    xvalid_o <= xreq_i;
                    xmiss_o <= miss_i;
                    xzone_o <= zone_i;
                    ack_o <= mreq_i;
                    rdata_o <= mem_word(maddr_i);
                end
            end
        end
    end
endmodule

// ===== tb/tb_top.sv
// self-checking bench for the load unit
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %s expected %h seen %h", n, e, g); end end
module tb_top;
    typedef struct packed {logic exc; logic [4:0] idx; logic [31:0] val;} ldu_note_t;
    logic clk_i = 1'h0, reset_n_i = 1'h0, issue_valid_i = 1'h0, issue_reversed_i = 1'h0;
    logic prefix_valid_i = 1'h0, other_issue_i = 1'h0, msr_write_i = 1'h0;
    logic msr_user_i = 1'h0, msr_virtual_i = 1'h0, xl_miss_i = 1'h0, xl_zone_i = 1'h0;
    ldu_pkg::ldu_op_t issue_op_i = ldu_pkg::LDU_OP_BYTE_IMM;
    logic [31:0] first_src_gpr_i = 32'h0, second_src_gpr_i = 32'h0, got;
    logic [15:0] imm_field_i = 16'h0, prefix_value_i = 16'h0, seed = 16'h544f;
    logic [4:0] dest_idx_i = 5'h0, wb_idx_o, exc_reg_idx_o, exception_cause_code_o;
    logic [1:0] lag_i = 2'h0;
    logic issue_ready_o, illegal_o, irq_hold_o, user_mode_flag_o, virtual_mode_flag_o;
    logic saved_user_flag_o, saved_virtual_flag_o, xlate_req_o, xlate_valid_i, xlate_miss_i;
    logic zone_forbid_i, mem_req_o, mem_ack_i, wb_valid_o, exc_valid_o, exc_store_o;
    logic zone_protect_cause_o, exc_word_o;
    logic [31:0] xlate_addr_o, mem_addr_o, mem_rdata_i, wb_data_o;
    ldu_pkg::ldu_size_t mem_size_o;
    int failures = 0, checks = 0;
    ldu_note_t notes[$], n;
    ldu_load_unit #(.area_optimised_param(1'h0), .reorder_enable_param(1'h1)) uut (.*);
    ldu_mem_model pm (.clk_i(clk_i), .reset_n_i(reset_n_i), .xreq_i(xlate_req_o),
        .mreq_i(mem_req_o), .maddr_i(mem_addr_o), .miss_i(xl_miss_i), .zone_i(xl_zone_i),
        .lag_i(lag_i), .xvalid_o(xlate_valid_i), .xmiss_o(xlate_miss_i),
        .xzone_o(zone_forbid_i), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
    always #25 clk_i = ~clk_i;
    // two lfsr steps give one 32-bit random value
    function automatic logic [31:0] rnd();
        for (int k = 0; k < 2; k++) begin
            seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
            rnd = {rnd[15:0], seed};
        end
    endfunction
    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // one random load: mode, optional prefix, operands, expected note, then wait
    task automatic run(input int i);
        ldu_note_t e;
        logic [31:0] a, b, ad, ea, d, sx, c, r;
        logic rg, hf, rv, pre, m, z, un;
        ldu_pkg::ldu_op_t op;
        op = ldu_pkg::ldu_op_t'(i % 4);
        a = rnd();
        b = rnd();
        r = rnd();
        c = rnd();
        rg = op inside {ldu_pkg::LDU_OP_HALF_REG, ldu_pkg::LDU_OP_WORD_REG};
        hf = op inside {ldu_pkg::LDU_OP_HALF_REG, ldu_pkg::LDU_OP_HALF_IMM};
        rv = c[0] && rg;
        pre = c[1] && !rg;
        @(negedge clk_i);
        msr_write_i = 1'h1;
        {msr_user_i, msr_virtual_i, xl_miss_i, xl_zone_i, lag_i} = c[8:3];
        @(negedge clk_i);
        msr_write_i = 1'h0;
        if (pre) begin
            prefix_valid_i = 1'h1;
            prefix_value_i = r[31:16];
            @(negedge clk_i);
            prefix_valid_i = 1'h0;
            other_issue_i = c[2];
            `CHK("hold", 1'h1, irq_hold_o)
            @(negedge clk_i);
            other_issue_i = 1'h0;
        end
        sx = (pre && !c[2]) ? {r[31:16], r[15:0]} : {{16{r[15]}}, r[15:0]};
        ad = rg ? a + b : a + sx;
        // most loads aligned so data paths see traffic, the rest hit the checks
        if (c[10:9] != 2'h0) begin
            a = a - {30'h0, ad[1:0]};
            ad = ad - {30'h0, ad[1:0]};
        end
        ea = (rv && hf) ? ad ^ 32'h2 : ad;
        m = msr_virtual_i && xl_miss_i;
        z = msr_user_i && msr_virtual_i && xl_zone_i && !m;
        un = (op == ldu_pkg::LDU_OP_WORD_REG) ? (ea[1:0] != 2'h0) : (hf && ea[0]);
        d = pm.mem_word(ea);
        e = '{exc: m || z || un, idx: i[4:0], val: d};
        if (m) e.val = {20'h0, 5'h12, 7'h0};
        else if (z) e.val = {19'h0, 1'h1, 5'h10, 7'h0};
        else if (un) e.val = {20'h0, 5'h01, 1'h0, !hf, i[4:0]};
        else if (!hf && !rg) e.val = {24'h0, d[7:0]};
        else if (hf) e.val = rv ? {16'h0, d[7:0], d[15:8]} : {16'h0, d[15:0]};
        else if (rv) e.val = {d[7:0], d[15:8], d[23:16], d[31:24]};
        notes.push_back(e);
        issue_valid_i = 1'h1;
        issue_op_i = op;
        issue_reversed_i = rv;
        {first_src_gpr_i, second_src_gpr_i, imm_field_i, dest_idx_i} = {a, b, r[15:0], i[4:0]};
        @(negedge clk_i);
        issue_valid_i = 1'h0;
        `CHK("refuse", 1'h0, illegal_o)
        // upper address bits never reach the data pattern, so the address is compared directly
        `CHK("addr", ea, xlate_addr_o)
        `CHK("release", 1'h0, irq_hold_o)
        for (int k = 0; k < 40 && issue_ready_o !== 1'h1; k++) @(negedge clk_i);
        // a load that never finishes counts as a mismatch
        `CHK("ready", 1'h1, issue_ready_o)
        repeat (2) @(negedge clk_i);
        $display("load %0d done", i);
    endtask
    // each result pulse takes the oldest note and compares
    always @(negedge clk_i) begin
        if (wb_valid_o === 1'h1 || exc_valid_o === 1'h1) begin
            n = notes.pop_front();
            got = {19'h0, zone_protect_cause_o & n.val[12], exception_cause_code_o,
                exc_store_o, exc_word_o & n.val[11:7] == 5'h01, exc_reg_idx_o};
            if (n.val[11:7] != 5'h01) got[4:0] = n.val[4:0];
            `CHK("kind", n.exc, exc_valid_o)
            if (n.exc) `CHK("status", n.val, got)
            else `CHK("data", n.val, wb_data_o)
            if (!n.exc) `CHK("index", n.idx, wb_idx_o)
        end
    end
    initial begin
        repeat (10) @(posedge clk_i);
        @(negedge clk_i);
        reset_n_i = 1'h1;
        for (int i = 0; i < 64; i++) run(i);
        repeat (4) @(negedge clk_i);
        `CHK("left", 0, notes.size())
        complete_run();
    end
    // watchdog: 64 loads take well under 60 cycles each
    initial begin
        repeat (6000) @(posedge clk_i);
        failures++;
        complete_run();
    end
endmodule
